// ==== design/fsi_map.svh ====
// opcode, field and timing constants of the flash command core
// assumes a 25 MHz core clock; included by bare name
`ifndef FSI_MAP_SVH
`define FSI_MAP_SVH
`define FSI_OP_WRSR1      8'h01
`define FSI_OP_WRSR2      8'h31
`define FSI_OP_PROG       8'h02
`define FSI_OP_QPROG      8'h33
`define FSI_OP_ERASE4K    8'h20
`define FSI_OP_ERASE32K   8'h52
`define FSI_OP_ERASE64K   8'hd8
`define FSI_OP_CHIPA      8'hc7
`define FSI_OP_CHIPB      8'h60
`define FSI_OP_SUSPEND    8'h75
`define FSI_OP_RESUME     8'h7a
`define FSI_OP_PWRDOWN    8'hb9
`define FSI_OP_RELEASE    8'hab
`define FSI_OP_ID_SINGLE  8'h90
`define FSI_OP_ID_DUAL    8'h92
`define FSI_OPC_BITS      6'h08
`define FSI_HDR_BITS      6'h20
`define FSI_CLK_MHZ       25
`define FSI_RESUME_NS     200
`define FSI_RESUME_CYC    ((`FSI_RESUME_NS * `FSI_CLK_MHZ) / 1000)
`define FSI_SUS_LAT_CYC   16'h00fa
`define FSI_PD_ENTRY_CYC  16'h004b
`define FSI_WAKE_CYC      16'h004b
`define FSI_IDREC_CYC     16'h004b
`endif

// ==== design/fsi_pkg.sv ====
// types of the flash command core
// assumes fsi_map.svh for the numeric constants
package fsi_pkg;
  typedef enum logic [4:0] {
    PWR_STBY  = 5'h01,
    PWR_ENTER = 5'h02,
    PWR_DOWN  = 5'h04,
    PWR_WAKE  = 5'h08,
    PWR_RECOV = 5'h10
  } fsi_pwr_e;
  typedef enum logic [1:0] {
    KIND_PROG = 2'h0,
    KIND_BLK  = 2'h1,
    KIND_CHIP = 2'h2
  } fsi_kind_e;
  typedef struct packed {
    logic       sck;
    logic       cs_n;
    logic [3:0] io;
  } fsi_pins_s;
  typedef struct packed {
    fsi_pins_s  s1;
    fsi_pins_s  s2;
    fsi_pins_s  s3;
    logic       sck_f;
    logic       cs_f;
    fsi_pwr_e   pwr;
    logic [15:0] pwr_tmr;
    logic       busy;
    logic       susp;
    logic       hold;
    fsi_kind_e  run_kind;
    fsi_kind_e  susp_kind;
    logic [15:0] sus_tmr;
    logic [5:0] fr_bits;
    logic [7:0] fr_op;
    logic       fr_lsb;
    logic       tx;
    logic       byte_sel;
    logic [7:0] out_sh;
    logic [2:0] out_bits;
    logic [3:0] io_out;
    logic [3:0] io_oe;
    logic [7:0] opc;
    logic       opc_stb;
    logic       dpd;
    logic       ready;
  } fsi_state_s;
endpackage : fsi_pkg

// ==== design/fsi_cmd_core.sv ====
// flash command core: suspend/resume, deep power-down, release and id reads
// assumes SCK, CS_N and IO_IN come from the link; OP_* from the engine domain
`timescale 1ns/1ps
`default_nettype none
`include "fsi_map.svh"

module fsi_cmd_core #(
  parameter logic [15:0] SUS_LAT_CYC  = `FSI_SUS_LAT_CYC,
  parameter logic [15:0] PD_ENTRY_CYC = `FSI_PD_ENTRY_CYC,
  parameter logic [15:0] WAKE_CYC     = `FSI_WAKE_CYC,
  parameter logic [15:0] IDREC_CYC    = `FSI_IDREC_CYC,
  parameter logic [7:0]  MFR_ID       = 8'h5a, // arbitrary value
  parameter logic [7:0]  DEV_ID       = 8'h3c  // arbitrary value
) (
  input  wire logic              CORE_CLK,
  input  wire logic              ARST_N,
  input  wire logic              SCK,
  input  wire logic              CS_N,
  input  wire logic [3:0]        IO_IN,
  output logic      [3:0]        IO_OUT,
  output logic      [3:0]        IO_OE,
  input  wire logic              QUAD_INSTRUCTION_MODE,
  input  wire logic              OP_START,
  input  wire fsi_pkg::fsi_kind_e OP_KIND,
  input  wire logic              OP_DONE,
  output logic                   BUSY,
  output logic                   SUSPEND_FLAG,
  output logic                   ENG_HOLD,
  output logic                   DEEP_PD,
  output logic                   CMD_READY,
  output logic      [7:0]        OPCODE,
  output logic                   OPCODE_STB
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  fsi_pkg::fsi_state_s r_reg;
  fsi_pkg::fsi_state_s r_next;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic       sck_rise;
    logic       sck_fall;
    logic       cs_rise;
    logic       cs_fall;
    logic [2:0] w;
    logic [3:0] din;
    logic [7:0] data;
    logic [7:0] op;
    logic       lock;
    logic       own_op;
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    cs_rise  = 1'b0;
    cs_fall  = 1'b0;
    w        = 3'h1;
    din      = 4'h0;
    data     = 8'h00;
    op       = 8'h00;
    lock     = 1'b0;
    own_op   = 1'b0;
    r_next   = r_reg;
    r_next.opc_stb = 1'b0;

    // pin synchronisers: a change counts when stages 2 and 3 agree
    r_next.s1 = '{sck: SCK, cs_n: CS_N, io: IO_IN};
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    if (r_reg.s2.sck == r_reg.s3.sck) begin
      r_next.sck_f = r_reg.s3.sck;
    end
    if (r_reg.s2.cs_n == r_reg.s3.cs_n) begin
      r_next.cs_f = r_reg.s3.cs_n;
    end
    sck_rise = !r_reg.sck_f && r_next.sck_f;
    sck_fall = r_reg.sck_f && !r_next.sck_f;
    cs_rise  = !r_reg.cs_f && r_next.cs_f;
    cs_fall  = r_reg.cs_f && !r_next.cs_f;

    // lines per clock
    if (QUAD_INSTRUCTION_MODE) begin
      w = 3'h4;
    end else if (r_reg.fr_op == `FSI_OP_ID_DUAL && r_reg.fr_bits >= `FSI_OPC_BITS) begin
      w = 3'h2;
    end

    // engine cycle tracking
    if (OP_START && !r_reg.busy) begin
      r_next.busy     = 1'b1;
      r_next.run_kind = OP_KIND;
    end
    if (OP_DONE && r_reg.busy && !r_reg.hold) begin
      r_next.busy = 1'b0;
    end
    if (r_reg.hold && r_reg.busy) begin
      if (r_reg.sus_tmr == 16'h0000) begin
        r_next.busy = 1'b0;
      end else begin
        r_next.sus_tmr = r_reg.sus_tmr - 16'h0001;
      end
    end

    // power state timers
    case (r_reg.pwr)
      fsi_pkg::PWR_ENTER, fsi_pkg::PWR_WAKE, fsi_pkg::PWR_RECOV: begin
        if (r_reg.pwr_tmr == 16'h0000) begin
          r_next.pwr = (r_reg.pwr == fsi_pkg::PWR_ENTER) ? fsi_pkg::PWR_DOWN
                                                          : fsi_pkg::PWR_STBY;
        end else begin
          r_next.pwr_tmr = r_reg.pwr_tmr - 16'h0001;
        end
      end
      default: begin
        r_next.pwr_tmr = 16'h0000;
      end
    endcase

    // frame start
    if (cs_fall) begin
      r_next.fr_bits  = 6'h00;
      r_next.fr_op    = 8'h00;
      r_next.tx       = 1'b0;
      r_next.out_bits = 3'h0;
    end

    // shift in opcode and address on rising sck
    if (!r_reg.cs_f && sck_rise && !r_reg.tx) begin
      din = r_reg.s3.io;
      if (r_reg.fr_bits < `FSI_OPC_BITS) begin
        case (w)
          3'h4:    op = {r_reg.fr_op[3:0], din};
          default: op = {r_reg.fr_op[6:0], din[0]};
        endcase
        r_next.fr_op = op;
      end else begin
        op = r_reg.fr_op;
      end
      r_next.fr_lsb = din[0];
      if (r_reg.fr_bits < `FSI_HDR_BITS) begin
        r_next.fr_bits = r_reg.fr_bits + {3'h0, w};
      end else if (r_reg.fr_bits != 6'h3f) begin
        r_next.fr_bits = r_reg.fr_bits + 6'h01;
      end
      // opcode complete
      if (r_reg.fr_bits < `FSI_OPC_BITS && r_next.fr_bits == `FSI_OPC_BITS) begin
        own_op = (op == `FSI_OP_SUSPEND) || (op == `FSI_OP_RESUME) ||
                 (op == `FSI_OP_PWRDOWN) || (op == `FSI_OP_RELEASE) ||
                 (op == `FSI_OP_ID_SINGLE) || (op == `FSI_OP_ID_DUAL);
        if (r_reg.susp) begin
          lock = (op == `FSI_OP_WRSR1) || (op == `FSI_OP_WRSR2) ||
                 (op == `FSI_OP_ERASE4K) || (op == `FSI_OP_ERASE32K) ||
                 (op == `FSI_OP_ERASE64K) || (op == `FSI_OP_CHIPA) ||
                 (op == `FSI_OP_CHIPB);
          if (r_reg.susp_kind == fsi_pkg::KIND_PROG) begin
            lock = lock || (op == `FSI_OP_PROG) || (op == `FSI_OP_QPROG);
          end
        end
        if (r_reg.pwr == fsi_pkg::PWR_STBY && !own_op && !lock) begin
          r_next.opc     = op;
          r_next.opc_stb = 1'b1;
        end
      end
      // header complete: start identifier output
      if (r_reg.fr_bits < `FSI_HDR_BITS && r_next.fr_bits >= `FSI_HDR_BITS &&
          !r_reg.busy) begin
        if ((op == `FSI_OP_ID_SINGLE || op == `FSI_OP_ID_DUAL) &&
            r_reg.pwr == fsi_pkg::PWR_STBY) begin
          r_next.tx       = 1'b1;
          r_next.byte_sel = din[0];
        end else if (op == `FSI_OP_RELEASE && !QUAD_INSTRUCTION_MODE &&
                     (r_reg.pwr == fsi_pkg::PWR_STBY || r_reg.pwr == fsi_pkg::PWR_DOWN)) begin
          r_next.tx       = 1'b1;
          r_next.byte_sel = 1'b1;
        end
      end
    end

    // shift out identifier on falling sck, msb first
    if (!r_reg.cs_f && sck_fall && r_reg.tx) begin
      if (r_reg.out_bits == 3'h0) begin
        data = r_reg.byte_sel ? DEV_ID : MFR_ID;
        if (r_reg.fr_op != `FSI_OP_RELEASE) begin
          r_next.byte_sel = !r_reg.byte_sel;
        end
      end else begin
        data = r_reg.out_sh;
      end
      case (w)
        3'h4: begin
          r_next.io_out = data[7:4];
          r_next.io_oe  = 4'hf;
          r_next.out_sh = {data[3:0], 4'h0};
        end
        3'h2: begin
          r_next.io_out = {2'h0, data[7:6]};
          r_next.io_oe  = 4'h3;
          r_next.out_sh = {data[5:0], 2'h0};
        end
        default: begin
          r_next.io_out = {2'h0, data[7], 1'b0};
          r_next.io_oe  = 4'h2;
          r_next.out_sh = {data[6:0], 1'b0};
        end
      endcase
      r_next.out_bits = r_reg.out_bits + w;
    end

    // frame end
    if (cs_rise) begin
      r_next.tx    = 1'b0;
      r_next.io_oe = 4'h0;
      if (r_reg.fr_bits >= `FSI_OPC_BITS) begin
        case (r_reg.pwr)
          fsi_pkg::PWR_STBY: begin
            if (r_reg.fr_op == `FSI_OP_PWRDOWN && r_reg.fr_bits == `FSI_OPC_BITS) begin
              r_next.pwr     = fsi_pkg::PWR_ENTER;
              r_next.pwr_tmr = PD_ENTRY_CYC;
            end else if (r_reg.fr_op == `FSI_OP_SUSPEND && !r_reg.susp && r_reg.busy &&
                         !r_reg.hold && r_reg.run_kind != fsi_pkg::KIND_CHIP) begin
              r_next.susp      = 1'b1;
              r_next.hold      = 1'b1;
              r_next.susp_kind = r_reg.run_kind;
              r_next.sus_tmr   = SUS_LAT_CYC;
            end else if (r_reg.fr_op == `FSI_OP_RESUME && r_reg.susp && !r_reg.busy) begin
              r_next.susp     = 1'b0;
              r_next.busy     = 1'b1;
              r_next.hold     = 1'b0;
              r_next.run_kind = r_reg.susp_kind;
            end else if (r_reg.fr_op == `FSI_OP_RELEASE && r_reg.tx) begin
              r_next.pwr     = fsi_pkg::PWR_RECOV;
              r_next.pwr_tmr = IDREC_CYC;
            end
          end
          fsi_pkg::PWR_DOWN: begin
            if (r_reg.fr_op == `FSI_OP_RELEASE && !r_reg.busy) begin
              r_next.pwr     = fsi_pkg::PWR_WAKE;
              r_next.pwr_tmr = WAKE_CYC;
            end
          end
          default: begin
            r_next.pwr = r_reg.pwr;
          end
        endcase
      end
    end

    r_next.dpd   = (r_next.pwr == fsi_pkg::PWR_DOWN);
    r_next.ready = (r_next.pwr == fsi_pkg::PWR_STBY);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      r_reg         <= '0;
      r_reg.s1.cs_n <= 1'b1;
      r_reg.s2.cs_n <= 1'b1;
      r_reg.s3.cs_n <= 1'b1;
      r_reg.cs_f    <= 1'b1;
      r_reg.pwr     <= fsi_pkg::PWR_STBY;
      r_reg.ready   <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign IO_OUT       = r_reg.io_out;
  assign IO_OE        = r_reg.io_oe;
  assign BUSY         = r_reg.busy;
  assign SUSPEND_FLAG = r_reg.susp;
  assign ENG_HOLD     = r_reg.hold;
  assign DEEP_PD      = r_reg.dpd;
  assign CMD_READY    = r_reg.ready;
  assign OPCODE       = r_reg.opc;
  assign OPCODE_STB   = r_reg.opc_stb;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  localparam int A_SUS_MAX = int'(SUS_LAT_CYC) + 2;

  a_susp_needs_busy: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    $rose(r_reg.susp) |-> $past(r_reg.busy) && !$past(r_reg.hold))
    else $error("suspend taken while idle");

  a_chip_no_susp: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (r_reg.busy && !r_reg.susp && r_reg.run_kind == fsi_pkg::KIND_CHIP) |=> !r_reg.susp)
    else $error("chip erase suspended");

  a_susp_busy_drop: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    $rose(r_reg.susp) |-> r_reg.hold ##[1:A_SUS_MAX] !r_reg.busy)
    else $error("busy not cleared after suspend");

  a_resume_gate: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    $fell(r_reg.susp) |-> !$past(r_reg.busy))
    else $error("resume taken while busy");

  a_resume_busy: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    $fell(r_reg.susp) |-> ##[0:4] (r_reg.busy && !r_reg.hold))
    else $error("busy not raised after resume");

  a_pd_exact_byte: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (r_reg.pwr == fsi_pkg::PWR_ENTER && $past(r_reg.pwr) != fsi_pkg::PWR_ENTER) |->
      ($past(r_reg.fr_op) == `FSI_OP_PWRDOWN && $past(r_reg.fr_bits) == `FSI_OPC_BITS))
    else $error("power-down entered on bad frame");

  a_pd_ignores_ops: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (r_reg.pwr != fsi_pkg::PWR_STBY) |=> !r_reg.opc_stb)
    else $error("opcode passed while powered down");

  a_lock_erase: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (r_reg.opc_stb && r_reg.susp) |->
      !(r_reg.opc inside {`FSI_OP_WRSR1, `FSI_OP_WRSR2, `FSI_OP_ERASE4K,
        `FSI_OP_ERASE32K, `FSI_OP_ERASE64K, `FSI_OP_CHIPA, `FSI_OP_CHIPB}))
    else $error("locked opcode passed while suspended");

  a_lock_prog: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    (r_reg.opc_stb && r_reg.susp && r_reg.susp_kind == fsi_pkg::KIND_PROG) |->
      !(r_reg.opc inside {`FSI_OP_PROG, `FSI_OP_QPROG}))
    else $error("page program passed while program suspended");

  a_id_not_busy: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
    $rose(r_reg.tx) |-> !$past(r_reg.busy))
    else $error("id read started while busy");

endmodule : fsi_cmd_core
`default_nettype wire

// ==== tb/fsi_host_model.sv ====
// serial host model that drives the link pins of the command core
// assumes mode 0 framing; the bench calls xfer hierarchically
`timescale 1ns/1ps
`default_nettype none
module fsi_host_model (
  output logic            SCK_O,
  output logic            CS_N_O,
  output logic      [3:0] IO_O,
  input  wire logic [3:0] IO_I
);
  initial begin
    SCK_O  = 1'b0;
    CS_N_O = 1'b1;
    IO_O   = 4'h0;
  end
  // ---------------------------------------------------------------
  // one frame: nb header bits, w per clock (1 for the first 8 if w is 2), then nrd clocks read (io1, io1:io0 if w is 2)
  // ---------------------------------------------------------------
  task automatic xfer(input logic [63:0] tx, input int nb, input int w,
                      input int nrd, output logic [31:0] rx);
    int s;
    rx = 32'h0;
    s = w;
    CS_N_O = 1'b0;
    for (int i = 0; i < nb; i += s) begin
      s = (w == 2 && i < 8) ? 1 : w;
      IO_O = (s == 4) ? tx[63:60] :
             (s == 2) ? {IO_O[3:2], tx[63:62]} : {IO_O[3:1], tx[63]};
      tx = tx << s;
      #160 SCK_O = 1'b1;
      #160 SCK_O = 1'b0;
    end
    IO_O = ~IO_O; // released lines never hold the last value
    for (int i = 0; i < nrd; i++) begin
      #160 SCK_O = 1'b1;
      #160 rx = (w == 2) ? {rx[29:0], IO_I[1:0]} : {rx[30:0], IO_I[1]};
      SCK_O = 1'b0;
    end
    #160 CS_N_O = 1'b1;
    #640; // cs held high past every delay
  endtask : xfer
endmodule : fsi_host_model
`default_nettype wire

// ==== tb/fsi_cmd_core_tb_top.sv ====
// bench for the flash command core: link frames and engine pulses
// assumes the host model above and small delay parameters
`timescale 1ns/1ps
`default_nettype none
module fsi_cmd_core_tb_top;
  localparam logic [7:0] MFR = 8'ha6; // arbitrary value
  localparam logic [7:0] DEV = 8'h71; // arbitrary value
  logic               core_clk;
  logic               arst_n;
  logic               quad;
  logic               op_start;
  logic               op_done;
  fsi_pkg::fsi_kind_e op_kind;
  logic               sck;
  logic               cs_n;
  logic [3:0]         io_h;
  logic [3:0]         io_out;
  logic [3:0]         io_oe;
  logic [3:0]         io_w;
  logic               busy;
  logic               susp;
  logic               hold;
  logic               dpd;
  logic               rdy;
  logic [7:0]         opc;
  logic               stb;
  logic [31:0]        rx;
  int                 num_errors = 0;
  int                 total_checks = 0;
  int                 stb_cnt = 0;
  int                 oe_cnt = 0;
  int                 cyc = 0;
  int                 n;
  int                 m;

  assign io_w = (io_oe & io_out) | (~io_oe & io_h);

  fsi_host_model host_u (.SCK_O(sck), .CS_N_O(cs_n), .IO_O(io_h), .IO_I(io_w));

  fsi_cmd_core #(.SUS_LAT_CYC(16'h0004), .PD_ENTRY_CYC(16'h0004),
    .WAKE_CYC(16'h0004), .IDREC_CYC(16'h0004), .MFR_ID(MFR), .DEV_ID(DEV)) dut_u (
    .CORE_CLK(core_clk), .ARST_N(arst_n), .SCK(sck), .CS_N(cs_n), .IO_IN(io_w),
    .IO_OUT(io_out), .IO_OE(io_oe), .QUAD_INSTRUCTION_MODE(quad),
    .OP_START(op_start), .OP_KIND(op_kind), .OP_DONE(op_done), .BUSY(busy),
    .SUSPEND_FLAG(susp), .ENG_HOLD(hold), .DEEP_PD(dpd), .CMD_READY(rdy),
    .OPCODE(opc), .OPCODE_STB(stb));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    stb_cnt <= stb_cnt + int'(stb);
    oe_cnt <= oe_cnt + int'(io_oe != 4'h0);
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic frame(input logic [63:0] tx, input int nb, input int w, input int nrd);
    @(negedge core_clk);
    host_u.xfer(tx, nb, w, nrd, rx);
  endtask : frame

  task automatic cmd(input logic [7:0] op);
    frame({op, 56'h0}, 8, quad ? 4 : 1, 0);
  endtask : cmd

  task automatic engine(input logic st, input fsi_pkg::fsi_kind_e k);
    @(posedge core_clk);
    op_start <= st;
    op_done  <= ~st;
    op_kind  <= k;
    @(posedge core_clk);
    op_start <= 1'b0;
    op_done  <= 1'b0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
  endtask : engine

  task automatic do_reset();
    @(posedge core_clk);
    arst_n <= 1'b0;
    quad   <= 1'b0;
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
  endtask : do_reset

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_erase_suspend();
    cmd(8'h75);
    check(susp, 1'b0);
    engine(1'b1, fsi_pkg::KIND_BLK);
    check(busy, 1'b1);
    cmd(8'h75);
    check({susp, busy, hold}, 3'b101);
    n = stb_cnt;
    cmd(8'h01);
    cmd(8'h31);
    cmd(8'h20);
    cmd(8'h52);
    cmd(8'hd8);
    cmd(8'hc7);
    cmd(8'h60);
    check(stb_cnt - n, 0);
    cmd(8'h02);
    check(stb_cnt - n, 1);
    check(opc, 8'h02);
    cmd(8'h7a);
    check({susp, busy, hold}, 3'b010);
    engine(1'b0, fsi_pkg::KIND_BLK);
    check(busy, 1'b0);
  endtask : t_erase_suspend

  task automatic t_chip_prog();
    engine(1'b1, fsi_pkg::KIND_CHIP);
    cmd(8'h75);
    check({susp, busy}, 2'b01);
    engine(1'b0, fsi_pkg::KIND_CHIP);
    @(posedge core_clk);
    quad <= 1'b1;
    engine(1'b1, fsi_pkg::KIND_PROG);
    cmd(8'h75);
    check({susp, busy}, 2'b10);
    n = stb_cnt;
    cmd(8'h33);
    cmd(8'h02);
    cmd(8'hc7);
    check(stb_cnt - n, 0);
    cmd(8'h05);
    check(stb_cnt - n, 1);
    do_reset();
    check({susp, busy, rdy}, 3'b001);
    cmd(8'h7a);
    check({susp, busy}, 2'b00);
  endtask : t_chip_prog

  task automatic t_power_down();
    frame({8'hb9, 56'h0}, 9, 1, 0);
    check(dpd, 1'b0);
    cmd(8'hb9);
    check({dpd, rdy}, 2'b10);
    n = stb_cnt;
    cmd(8'h05);
    cmd(8'h90);
    check(dpd, 1'b1);
    check(stb_cnt - n, 0);
    cmd(8'hab);
    check({dpd, rdy}, 2'b01);
  endtask : t_power_down

  task automatic t_ids();
    frame({8'hab, 56'h0}, 32, 1, 16);
    check(rx, {16'h0, DEV, DEV});
    frame({8'h90, 56'h0}, 32, 1, 16);
    check(rx, {16'h0, MFR, DEV});
    frame({8'h90, 24'h1, 32'h0}, 32, 1, 24);
    check(rx, {8'h0, DEV, MFR, DEV});
    check(io_oe, 4'h0);
    frame({8'h92, 24'h1, 32'h0}, 32, 2, 8);
    check(rx, {16'h0, DEV, MFR});
    @(posedge core_clk);
    quad <= 1'b1;
    m = oe_cnt;
    frame({8'hab, 56'h0}, 32, 4, 8);
    check(oe_cnt - m, 0);
    @(posedge core_clk);
    quad <= 1'b0;
    engine(1'b1, fsi_pkg::KIND_BLK);
    frame({8'hab, 56'h0}, 32, 1, 8);
    check(oe_cnt - m, 0);
    check(busy, 1'b1);
    engine(1'b0, fsi_pkg::KIND_BLK);
  endtask : t_ids

  initial begin
    arst_n = 1'b0;
    quad = 1'b0;
    op_start = 1'b0;
    op_done = 1'b0;
    op_kind = fsi_pkg::KIND_PROG;
    do_reset();
    check({busy, susp, hold, dpd, rdy}, 5'b00001);
    t_erase_suspend();
    t_chip_prog();
    t_power_down();
    t_ids();
    give_verdict();
  end
endmodule : fsi_cmd_core_tb_top
`default_nettype wire
